// ---- rtl/fpes_pkg.sv ----
// fpes_pkg: codes, qualifier bit positions, register offsets and carriers
// for the fabric performance event selector.
// assumes a single 125 MHz clock domain and an Avalon-MM register port.
package fpes_pkg;

    // ****************************************************************
    // event codes (12-bit event_code_field)
    // ****************************************************************
    localparam logic [11:0] EV_CMD_LAT = 12'h1E6;
    localparam logic [11:0] EV_CMD_REQ = 12'h1E7;
    localparam logic [11:0] EV_LINK0 = 12'h0F6;
    localparam logic [11:0] EV_LINK1 = 12'h0F7;
    localparam logic [11:0] EV_LINK2 = 12'h0F8;
    localparam logic [11:0] EV_LINK3 = 12'h1F9;
    localparam logic [11:0] EV_L3_READ = 12'h4E0;
    localparam logic [11:0] EV_L3_MISS = 12'h4E1;
    localparam logic [11:0] EV_L3_FILL = 12'h4E2;
    localparam logic [11:0] EV_L3_EVICT = 12'h4E3;

    // ****************************************************************
    // qualifier field positions
    // ****************************************************************
    localparam int Q_NODE_GRP = 3;
    localparam int Q_TGT_LO = 4;
    localparam int Q_SUBLINK = 7;
    localparam logic [7:0] Q_CMD_MASK = 8'h07;
    localparam logic [7:0] Q_LINK_MASK = 8'h3F;
    localparam logic [7:0] Q_STATE_MASK = 8'h0F;

    // ****************************************************************
    // register map (byte addresses, word aligned)
    // ****************************************************************
    localparam logic [3:0] A_SEL = 4'h0;
    localparam logic [3:0] A_CNT = 4'h4;
    localparam logic [3:0] A_STAT = 4'h8;
    localparam logic [31:0] SEL_RST = 32'h0000_0000;
    localparam int SEL_EN_BIT = 31;
    localparam logic [31:0] UNMAPPED_RD = 32'h0000_0000;

    // ****************************************************************
    // event carriers
    // ****************************************************************
    // command to a target node; node id 0..7
    typedef struct packed {
        logic start;
        logic done;
        logic [2:0] cmd_type;   // one-hot: sized rd, sized wr, victim
        logic [2:0] node;
    } fpes_cmd_t;

    // one dword slot per link per cycle
    typedef struct packed {
        logic valid;
        logic [5:0] category;   // one-hot dword category
        logic sublink;
    } fpes_link_t;

    // shared-cache event from a core
    typedef struct packed {
        logic read;
        logic miss;
        logic fill;
        logic evict;
        logic [2:0] req_type;   // one-hot request type
        logic [3:0] state;      // one-hot line state
        logic [1:0] core;
    } fpes_l3_t;

endpackage

// ---- rtl/fpes_lat_track.sv ----
// fpes_lat_track: follows one qualified command at a time and reports
// per-cycle latency and per-command completion increments.
// assumes start/done arrive on mclk_i, one command per tag at most.
`timescale 1ns/10ps
module fpes_lat_track (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic qual_start_i,
    input wire logic done_i,
    output logic busy_o,
    output logic lat_inc_o,
    output logic req_inc_o
);

    // ****************************************************************
    // tracker state
    // ****************************************************************
    typedef enum logic {
        FPES_IDLE = 1'b0,
        FPES_BUSY = 1'b1
    } fpes_trk_t;

    fpes_trk_t state_r;
    fpes_trk_t state_nxt;

    // a start while busy is ignored: only one command in flight
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            FPES_IDLE: begin
                if (qual_start_i) begin
                    state_nxt = FPES_BUSY;
                end
            end
            FPES_BUSY: begin
                if (done_i) begin
                    state_nxt = FPES_IDLE;
                end
            end
            default: state_nxt = FPES_IDLE;
        endcase
    end

    // state register
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            state_r <= FPES_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // count each cycle after the accepting start through the done cycle
    assign busy_o = (state_r == FPES_BUSY);
    assign lat_inc_o = busy_o;
    assign req_inc_o = busy_o && done_i;

endmodule // fpes_lat_track

// ---- rtl/fpes_top.sv ----
// fpes_top: performance event qualification and counter with Avalon-MM
// register access.
// assumes fabric event inputs are synchronous to mclk_i.
`timescale 1ns/10ps
module fpes_top (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // avalon-mm slave
    input wire logic [3:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // fabric events
    input wire fpes_pkg::fpes_cmd_t cmd_i,
    input wire fpes_pkg::fpes_link_t [3:0] link_i,
    input wire fpes_pkg::fpes_l3_t l3_i,
    // qualified increment
    output logic inc_o
);

    // ****************************************************************
    // registers
    // ****************************************************************
    logic [31:0] sel_r;
    logic [31:0] cnt_r;
    logic [31:0] rdata_r;
    logic ack_r;

    wire [11:0] code = sel_r[11:0];
    wire [7:0] qual = sel_r[19:12];
    wire cnt_en = sel_r[fpes_pkg::SEL_EN_BIT];

    // merge byte lanes of a write into an old word
    function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] be);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // one-hot index test, shared by node and core matching
    function automatic logic sel_hit(input logic [3:0] mask,
                                     input logic [1:0] idx);
        return mask[idx];
    endfunction

    // ****************************************************************
    // command latency and request count
    // ****************************************************************
    wire cmd_type_hit = |(cmd_i.cmd_type & qual[2:0]);
    wire grp_hit = (cmd_i.node[2] == qual[fpes_pkg::Q_NODE_GRP]);
    wire node_hit = sel_hit(qual[7:4], cmd_i.node[1:0]);
    wire cmd_ev = (code == fpes_pkg::EV_CMD_LAT) ||
                  (code == fpes_pkg::EV_CMD_REQ);
    // type or node mismatch disqualifies the start itself
    wire cmd_qual = cnt_en && cmd_ev && cmd_i.start && cmd_type_hit &&
                    grp_hit && node_hit;
    wire lat_inc;
    wire req_inc;
    wire trk_busy;

    fpes_lat_track u_lat (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .qual_start_i(cmd_qual),
        .done_i(cmd_i.done),
        .busy_o(trk_busy),
        .lat_inc_o(lat_inc),
        .req_inc_o(req_inc)
    );

    // ****************************************************************
    // link transmit dwords
    // ****************************************************************
    // link index for the selected link code; 3'h4 means none
    wire [2:0] link_idx =
        (code == fpes_pkg::EV_LINK0) ? 3'h0 :
        (code == fpes_pkg::EV_LINK1) ? 3'h1 :
        (code == fpes_pkg::EV_LINK2) ? 3'h2 :
        (code == fpes_pkg::EV_LINK3) ? 3'h3 : 3'h4;
    wire fpes_pkg::fpes_link_t lnk = link_i[link_idx[1:0]];
    // nop is bit 3 per the encoding table, not bit 4
    wire [5:0] lnk_cat_mask = qual[5:0] & fpes_pkg::Q_LINK_MASK[5:0];
    wire lnk_cat_hit = |(lnk.category & lnk_cat_mask);
    // every slot carries exactly one category, so 3Fh counts all slots of the selected sublink
    wire lnk_sub_hit = (lnk.sublink == qual[fpes_pkg::Q_SUBLINK]);
    wire lnk_inc = !link_idx[2] && lnk.valid && lnk_cat_hit &&
                   lnk_sub_hit;

    // ****************************************************************
    // shared cache events
    // ****************************************************************
    wire core_hit = sel_hit(qual[7:4], l3_i.core);
    wire req_hit = |(l3_i.req_type & qual[2:0]);
    wire st_hit = |(l3_i.state & qual[3:0]);
    wire l3_rd_inc = (code == fpes_pkg::EV_L3_READ) && l3_i.read &&
                     req_hit && core_hit;
    wire l3_ms_inc = (code == fpes_pkg::EV_L3_MISS) && l3_i.miss &&
                     req_hit && core_hit;
    wire l3_fl_inc = (code == fpes_pkg::EV_L3_FILL) && l3_i.fill &&
                     st_hit && core_hit;
    // no core term here: evictions belong to no core
    wire l3_ev_inc = (code == fpes_pkg::EV_L3_EVICT) && l3_i.evict &&
                     st_hit;

    // ****************************************************************
    // increment select
    // ****************************************************************
    wire lat_sel = (code == fpes_pkg::EV_CMD_LAT) && lat_inc;
    wire req_sel = (code == fpes_pkg::EV_CMD_REQ) && req_inc;
    wire inc_any = cnt_en && (lat_sel || req_sel || lnk_inc || l3_rd_inc ||
                   l3_ms_inc || l3_fl_inc || l3_ev_inc);

    // ****************************************************************
    // bus decode
    // ****************************************************************
    wire acc = (avs_read_i || avs_write_i) && !ack_r;
    // writes land on the edge where waitrequest is seen low
    wire acc_done = (avs_read_i || avs_write_i) && ack_r;
    wire wr_sel = acc_done && avs_write_i &&
                  (avs_address_i == fpes_pkg::A_SEL);
    wire wr_cnt = acc_done && avs_write_i &&
                  (avs_address_i == fpes_pkg::A_CNT);
    wire [31:0] rd_mux =
        (avs_address_i == fpes_pkg::A_SEL) ? sel_r :
        (avs_address_i == fpes_pkg::A_CNT) ? cnt_r :
        (avs_address_i == fpes_pkg::A_STAT) ? {31'h0, trk_busy} :
        fpes_pkg::UNMAPPED_RD;

    // one wait cycle, then answer
    assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack_r;
    assign avs_readdata_o = rdata_r;

    // handshake and read data
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            ack_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
        end else begin
            ack_r <= acc;
            rdata_r <= acc ? rd_mux : rdata_r;
        end
    end

    // select register
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            sel_r <= fpes_pkg::SEL_RST;
        end else if (wr_sel) begin
            sel_r <= be_merge(sel_r, avs_writedata_i, avs_byteenable_i);
        end
    end

    // counter; a software write wins over an increment that cycle
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            cnt_r <= 32'h0000_0000;
        end else if (wr_cnt) begin
            cnt_r <= be_merge(cnt_r, avs_writedata_i, avs_byteenable_i);
        end else if (inc_any) begin
            cnt_r <= cnt_r + 32'h0000_0001;
        end
    end

    // registered increment pulse
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            inc_o <= 1'b0;
        end else begin
            inc_o <= inc_any;
        end
    end

endmodule // fpes_top

// ---- tb/fpes_monitor.sv ----
// fpes_monitor: port-level assertions for the event selector.
// assumes full-word select writes; mirrors select and tracker state.
`timescale 1ns/10ps
module fpes_monitor (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic [3:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic avs_waitrequest_o,
    input wire fpes_pkg::fpes_cmd_t cmd_i,
    input wire fpes_pkg::fpes_link_t [3:0] link_i,
    input wire fpes_pkg::fpes_l3_t l3_i,
    input wire logic inc_o
);
    // ****************************************************************
    // mirrored state and qualifier decode
    // ****************************************************************
    logic [31:0] sel_r;
    logic trk_r;
    logic [3:0] lm;
    wire logic [11:0] code = sel_r[11:0];
    wire logic [7:0] q = sel_r[19:12];
    wire logic [3:0] qn = q[7:4];
    wire logic en = sel_r[fpes_pkg::SEL_EN_BIT];
    wire logic go = cmd_i.start && |(cmd_i.cmd_type & q[2:0])
        && cmd_i.node[2] == q[3] && qn[cmd_i.node[1:0]];
    wire logic [3:0] lk = {code == fpes_pkg::EV_LINK3,
        code == fpes_pkg::EV_LINK2, code == fpes_pkg::EV_LINK1,
        code == fpes_pkg::EV_LINK0};
    wire logic rq = |(l3_i.req_type & q[2:0]) && qn[l3_i.core];
    wire logic st = |(l3_i.state & q[3:0]);
    // per-link slot match
    always_comb begin
        for (int k = 0; k < 4; k++) begin
            lm[k] = link_i[k].valid && |(link_i[k].category & q[5:0])
                && link_i[k].sublink == q[7];
        end
    end
    // byte lanes ignored: the bench only writes whole words to the select register
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            sel_r <= 32'h0000_0000;
            trk_r <= 1'b0;
        end else begin
            if (avs_write_i && !avs_waitrequest_o
                && avs_address_i == fpes_pkg::A_SEL)
                sel_r <= avs_writedata_i;
            trk_r <= cmd_i.done ? 1'b0 : (trk_r | go);
        end
    end
    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_lat_on;
        en && code == fpes_pkg::EV_CMD_LAT;
    endsequence
    a_lat_span: assert property (s_lat_on |=> inc_o == $past(trk_r))
        else $error("latency step mismatch");
    a_req_step: assert property (en && code == fpes_pkg::EV_CMD_REQ
        |=> inc_o == $past(trk_r && cmd_i.done))
        else $error("request step mismatch");
    a_link_bw: assert property (en && |lk |=> inc_o == $past(|(lk & lm)))
        else $error("link dword step mismatch");
    a_link_full: assert property (en && |lk && q[5:0] == 6'h3F
        && |(lk & lm) |=> inc_o)
        else $error("full rate slot not counted");
    a_l3_read: assert property (en && code == fpes_pkg::EV_L3_READ
        |=> inc_o == $past(l3_i.read && rq))
        else $error("cache read step mismatch");
    a_l3_miss: assert property (en && code == fpes_pkg::EV_L3_MISS
        |=> inc_o == $past(l3_i.miss && rq))
        else $error("cache miss step mismatch");
    a_l3_fill: assert property (en && code == fpes_pkg::EV_L3_FILL
        |=> inc_o == $past(l3_i.fill && st && qn[l3_i.core]))
        else $error("cache fill step mismatch");
    a_l3_evict: assert property (en && code == fpes_pkg::EV_L3_EVICT
        |=> inc_o == $past(l3_i.evict && st))
        else $error("cache evict step mismatch");
    a_one_wait: assert property ((avs_read_i || avs_write_i)
        && avs_waitrequest_o |=> !avs_waitrequest_o)
        else $error("wait state longer than one");
endmodule // fpes_monitor

bind fpes_top fpes_monitor i_mon (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .cmd_i(cmd_i),
    .link_i(link_i), .l3_i(l3_i), .inc_o(inc_o));

// ---- tb/tb.sv ----
// tb: self-checking bench for the event selector top.
// assumes one 125 MHz clock and the one-wait Avalon-MM slave.
`timescale 1ns/10ps
module tb;
    logic mclk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [3:0] avs_address_i = 4'h0;
    logic avs_read_i = 1'b0;
    logic avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = 32'h0000_0000;
    logic [3:0] avs_byteenable_i = 4'hF;
    logic [31:0] avs_readdata_o;
    logic avs_waitrequest_o;
    logic inc_o;
    fpes_pkg::fpes_cmd_t cmd_i = '0;
    fpes_pkg::fpes_link_t [3:0] link_i = '0;
    fpes_pkg::fpes_l3_t l3_i = '0;
    int n_mismatch = 0;
    int total_checks = 0;
    logic [31:0] rd;

    fpes_top i_dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
        .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
        .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
        .avs_byteenable_i(avs_byteenable_i),
        .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o), .cmd_i(cmd_i),
        .link_i(link_i), .l3_i(l3_i), .inc_o(inc_o));

    // free-running 8 ns clock
    initial forever #4 mclk_i = ~mclk_i;

    task complete_run;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    // held until waitrequest is sampled low; the watchdog cuts a hang
    task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk_i);
        avs_address_i <= a;
        avs_write_i <= w;
        avs_read_i <= !w;
        avs_writedata_i <= d;
        do @(posedge mclk_i); while (avs_waitrequest_o !== 1'b0);
        rd = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
    endtask

    task cfg(input logic [11:0] c, input logic [7:0] q);
        bus(1'b1, fpes_pkg::A_SEL, {1'b1, 11'h000, q, c});
        bus(1'b1, fpes_pkg::A_CNT, 32'h0000_0000);
    endtask

    task cnt(input logic [31:0] e);
        bus(1'b0, fpes_pkg::A_CNT, 32'h0000_0000);
        chk(rd, e);
    endtask

    task t_regs;
        bus(1'b1, 4'hC, 32'hFFFF_FFFF);
        bus(1'b0, 4'hC, 32'h0000_0000);
        chk(rd, fpes_pkg::UNMAPPED_RD);
        // low two byte lanes only; counting is off after reset
        avs_byteenable_i <= 4'h3;
        bus(1'b1, fpes_pkg::A_CNT, 32'hFFFF_FFFF);
        avs_byteenable_i <= 4'hF;
        bus(1'b0, fpes_pkg::A_CNT, 32'h0000_0000);
        chk(rd, 32'h0000_FFFF);
        bus(1'b0, fpes_pkg::A_STAT, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
    endtask

    // command of type t to node n, done d cycles after start
    task cmd_run(input logic [2:0] t, input logic [2:0] n, input int d);
        @(posedge mclk_i);
        cmd_i <= {2'b10, t, n};
        for (int i = 1; i < d; i++) begin
            @(posedge mclk_i);
            cmd_i <= (i == 3) ? {2'b10, t, n} : 8'h00;
        end
        @(posedge mclk_i);
        cmd_i <= {2'b01, t, n};
        @(posedge mclk_i);
        cmd_i <= 8'h00;
    endtask

    task t_lat;
        cfg(fpes_pkg::EV_CMD_LAT, 8'h21);
        cmd_run(3'b001, 3'd5, 7);
        cmd_run(3'b001, 3'd1, 7);
        cnt(32'h0000_0007);
        bus(1'b0, fpes_pkg::A_SEL, 32'h0000_0000);
        chk(rd, {1'b1, 11'h000, 8'h21, fpes_pkg::EV_CMD_LAT});
    endtask

    task t_req;
        cfg(fpes_pkg::EV_CMD_REQ, 8'h21);
        cmd_run(3'b001, 3'd1, 5);
        cmd_run(3'b010, 3'd1, 5);
        cmd_run(3'b001, 3'd1, 4);
        cnt(32'h0000_0002);
    endtask

    // nop s0, data s0, addr ext s0, nop s1 on link k only
    task link_run(input int k, input logic [7:0] q, input logic [31:0] e);
        logic [7:0] pat [4];
        logic [11:0] lc [4];
        pat = '{8'h90, 8'h84, 8'hA0, 8'h91};
        lc = '{fpes_pkg::EV_LINK0, fpes_pkg::EV_LINK1,
            fpes_pkg::EV_LINK2, fpes_pkg::EV_LINK3};
        cfg(lc[k], q);
        for (int j = 0; j < 4; j++) begin
            @(posedge mclk_i);
            link_i[k] <= pat[j];
        end
        @(posedge mclk_i);
        link_i <= '0;
        cnt(e);
    endtask

    task t_link;
        for (int k = 0; k < 4; k++)
            link_run(k, 8'h0A, 32'h0000_0002);
        link_run(3, 8'h3F, 32'h0000_0003);
        link_run(2, 8'hBF, 32'h0000_0001);
    endtask

    // all four flags, req 001, state 1000; core 1 then core 0
    task t_l3;
        logic [11:0] lc [4];
        logic [7:0] lq [4];
        logic [31:0] le [4];
        lc = '{fpes_pkg::EV_L3_READ, fpes_pkg::EV_L3_MISS,
            fpes_pkg::EV_L3_FILL, fpes_pkg::EV_L3_EVICT};
        lq = '{8'h21, 8'h21, 8'h28, 8'h28};
        le = '{32'h1, 32'h1, 32'h1, 32'h2};
        for (int j = 0; j < 4; j++) begin
            cfg(lc[j], lq[j]);
            @(posedge mclk_i);
            l3_i <= 13'h1E61;
            @(posedge mclk_i);
            l3_i <= 13'h1E60;
            @(posedge mclk_i);
            l3_i <= '0;
            cnt(le[j]);
        end
    endtask

    // main sequence after a 16-cycle reset
    initial begin
        repeat (16) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        t_regs;
        t_lat;
        t_req;
        t_link;
        t_l3;
        complete_run;
    end

    // run needs well under 2000 cycles
    initial begin
        repeat (20000) @(posedge mclk_i);
        n_mismatch++;
        complete_run;
    end
endmodule // tb
